// ### design/osc_pkg.sv
// Constants, types and helpers shared by the ORing switch control block.
// Function
// - Set accurate flag when reverse sense difference reaches code at bits 7:6; 00=0 mV.
// - Enable switch once local minus remote sense exceeds level chosen by bits 5:4.
// - Fast path disables switch when reverse difference falls to level at bits 3:2.
// - Fast disable must persist 40 ns (bit 1 clear) or 200 ns (bit 1 set).
// - Bit 0 set bypasses fast path; only accurate decision then turns switch off.
package osc_pkg;

    localparam int CLK_MHZ = 100;
    localparam int DEB_SHORT_NS = 40;
    localparam int DEB_LONG_NS = 200;
    localparam int DEB_SHORT_CYC_I = (DEB_SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int DEB_LONG_CYC_I = (DEB_LONG_NS * CLK_MHZ + 999) / 1000;
    localparam int DEB_W = 5;
    localparam logic [DEB_W-1:0] DEB_SHORT_CYC = DEB_W'(DEB_SHORT_CYC_I);
    localparam logic [DEB_W-1:0] DEB_LONG_CYC = DEB_W'(DEB_LONG_CYC_I);

    localparam int SENSE_W = 12;
    localparam int DIFF_W = 14;

    // Register map, byte addresses on the 8-bit register port.
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;

    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Status and interrupt bit positions.
    localparam int BIT_SWITCH = 0;
    localparam int BIT_ACCURATE = 1;
    localparam int BIT_FAST = 2;
    localparam int EV_W = 3;

    // Accurate threshold in mV; reserved codes map to the only legal level.
    localparam logic signed [DIFF_W-1:0] ACC_THR_0MV = 14'sh0000;

    // Enable levels in ADC codes of a 4096-code range: -0.5, 0, 1 and 2 percent.
    localparam logic signed [DIFF_W-1:0] EN_THR_M0P5 = -14'sh0014;
    localparam logic signed [DIFF_W-1:0] EN_THR_0 = 14'sh0000;
    localparam logic signed [DIFF_W-1:0] EN_THR_1 = 14'sh0029;
    localparam logic signed [DIFF_W-1:0] EN_THR_2 = 14'sh0052;

    // Fast disable levels in mV.
    localparam logic signed [DIFF_W-1:0] FAST_THR_M100 = -14'sh0064;
    localparam logic signed [DIFF_W-1:0] FAST_THR_M75 = -14'sh004B;
    localparam logic signed [DIFF_W-1:0] FAST_THR_M50 = -14'sh0032;
    localparam logic signed [DIFF_W-1:0] FAST_THR_M25 = -14'sh0019;

    typedef struct packed {
        logic [1:0] acc_thr;
        logic [1:0] en_thr;
        logic [1:0] fast_thr;
        logic fast_deb;
        logic fast_bypass;
    } osc_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } osc_bus_t;

    function automatic logic signed [DIFF_W-1:0] osc_fast_level(input logic [1:0] code);
        logic signed [DIFF_W-1:0] lvl;
        unique case (code)
            2'h0: lvl = FAST_THR_M100;
            2'h1: lvl = FAST_THR_M75;
            2'h2: lvl = FAST_THR_M50;
            2'h3: lvl = FAST_THR_M25;
        endcase
        return lvl;
    endfunction

    function automatic logic signed [DIFF_W-1:0] osc_sdiff(
        input logic signed [SENSE_W:0] a,
        input logic signed [SENSE_W:0] b
    );
        return DIFF_W'(a) - DIFF_W'(b);
    endfunction

endpackage

// ### design/osc_fast_trip.sv
// Debounced fast reverse-current comparator with bypass.
module osc_fast_trip
    import osc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [DIFF_W-1:0] rev_diff,
    input wire logic [1:0] thr_code,
    input wire logic long_deb,
    input wire logic bypass,
    output logic trip
);

    logic [DEB_W-1:0] cnt_ff;
    logic [DEB_W-1:0] nxt_cnt;
    logic below;
    logic [DEB_W-1:0] target;

    always_comb begin
        below = rev_diff <= osc_fast_level(thr_code);
        target = long_deb ? DEB_LONG_CYC : DEB_SHORT_CYC;
        nxt_cnt = cnt_ff;
        if (bypass || !below) begin
            nxt_cnt = '0;
        end else if (cnt_ff < target) begin
            nxt_cnt = cnt_ff + DEB_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // The count restarts on any sample above the level, so a glitch never trips.
    assign trip = !bypass && below && (cnt_ff >= target);

endmodule

// ### design/osc_oring_ctrl.sv
// ORing switch control: configuration, enable and disable decisions, interrupts.
//
// The plain strobed port and the address map were decided locally.
module osc_oring_ctrl
    import osc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SAMPLE_VALID,
    input wire logic signed [SENSE_W-1:0] REVERSE_SENSE_POS,
    input wire logic signed [SENSE_W-1:0] REVERSE_SENSE_NEG,
    input wire logic [SENSE_W-1:0] LOCAL_OUT_SENSE,
    input wire logic [SENSE_W-1:0] REMOTE_OUT_SENSE,
    output logic ORING_SWITCH_EN,
    output logic ACCURATE_FLAG,
    output logic IRQ
);

    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_ON = 2'b10
    } osc_state_t;

    osc_bus_t bus;
    osc_cfg_t cfg_ff;
    osc_cfg_t nxt_cfg;
    logic [EV_W-1:0] irq_st_ff;
    logic [EV_W-1:0] nxt_irq_st;
    logic [EV_W-1:0] irq_mask_ff;
    logic [EV_W-1:0] nxt_irq_mask;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    osc_state_t state_ff;
    osc_state_t nxt_state;
    logic acc_ff;
    logic nxt_acc;
    logic sw_en_ff;
    logic nxt_sw_en;
    logic signed [DIFF_W-1:0] rev_diff;
    logic signed [DIFF_W-1:0] out_diff;
    logic signed [DIFF_W-1:0] en_level;
    logic acc_hit;
    logic en_hit;
    logic fast_trip;
    logic [EV_W-1:0] events;
    logic [7:0] status_word;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // Both differences are formed from the live pins every cycle.
    assign rev_diff = osc_sdiff({REVERSE_SENSE_POS[SENSE_W-1], REVERSE_SENSE_POS},
                                {REVERSE_SENSE_NEG[SENSE_W-1], REVERSE_SENSE_NEG});
    assign out_diff = osc_sdiff({1'b0, LOCAL_OUT_SENSE}, {1'b0, REMOTE_OUT_SENSE});

    // Configuration register.
    always_comb begin
        nxt_cfg = cfg_ff;
        if (bus.wr && bus.addr == ADDR_CONFIG) begin
            nxt_cfg = osc_cfg_t'(bus.wdata);
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_ff <= osc_cfg_t'(CONFIG_RESET);
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // Decision levels are decoded straight from the live fields, never shadowed.
    always_comb begin
        unique case (cfg_ff.en_thr)
            2'h0: en_level = EN_THR_M0P5;
            2'h1: en_level = EN_THR_0;
            2'h2: en_level = EN_THR_1;
            2'h3: en_level = EN_THR_2;
        endcase
    end

    // Reserved accurate codes fall back to the 0 mV level rather than misbehave.
    assign acc_hit = rev_diff <= ACC_THR_0MV;
    assign en_hit = out_diff > en_level;

    osc_fast_trip u_fast (
        .clk(MCLK),
        .rst_n(RESET_N),
        .rev_diff(rev_diff),
        .thr_code(cfg_ff.fast_thr),
        .long_deb(cfg_ff.fast_deb),
        .bypass(cfg_ff.fast_bypass),
        .trip(fast_trip)
    );

    // Accurate flag follows each conversion.
    always_comb begin
        nxt_acc = acc_ff;
        if (SAMPLE_VALID) begin
            nxt_acc = acc_hit;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // Switch state machine.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF: begin
                if (SAMPLE_VALID && en_hit && !acc_hit) begin
                    nxt_state = ST_ON;
                end
            end
            ST_ON: begin
                if (fast_trip) begin
                    nxt_state = ST_OFF;
                end else if (SAMPLE_VALID && acc_hit) begin
                    nxt_state = ST_OFF;
                end
            end
            default: nxt_state = ST_OFF;
        endcase
        nxt_sw_en = nxt_state == ST_ON;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= ST_OFF;
            sw_en_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sw_en_ff <= nxt_sw_en;
        end
    end

    // Events: accurate flag rising, switch turned on, switch killed by the fast path.
    always_comb begin
        events = '0;
        events[BIT_SWITCH] = nxt_sw_en && !sw_en_ff;
        events[BIT_ACCURATE] = nxt_acc && !acc_ff;
        events[BIT_FAST] = (state_ff == ST_ON) && fast_trip;
    end

    // Interrupt status and mask; a new event wins over a clear in the same cycle.
    always_comb begin
        nxt_irq_st = irq_st_ff;
        nxt_irq_mask = irq_mask_ff;
        if (bus.wr && bus.addr == ADDR_IRQ_STATUS) begin
            nxt_irq_st = irq_st_ff & ~bus.wdata[EV_W-1:0];
        end
        if (bus.wr && bus.addr == ADDR_IRQ_MASK) begin
            nxt_irq_mask = bus.wdata[EV_W-1:0];
        end
        nxt_irq_st = nxt_irq_st | events;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_st_ff <= IRQ_RESET;
            irq_mask_ff <= IRQ_RESET;
        end else begin
            irq_st_ff <= nxt_irq_st;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // Read port: data stand in the cycle after the strobe only.
    always_comb begin
        status_word = '0;
        status_word[BIT_SWITCH] = sw_en_ff;
        status_word[BIT_ACCURATE] = acc_ff;
        status_word[BIT_FAST] = fast_trip;
        nxt_rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_CONFIG: nxt_rdata = cfg_ff;
                ADDR_STATUS: nxt_rdata = status_word;
                ADDR_IRQ_STATUS: nxt_rdata = {{(8 - EV_W){1'b0}}, irq_st_ff};
                ADDR_IRQ_MASK: nxt_rdata = {{(8 - EV_W){1'b0}}, irq_mask_ff};
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;
    assign ORING_SWITCH_EN = sw_en_ff;
    assign ACCURATE_FLAG = acc_ff;
    assign IRQ = |(irq_st_ff & irq_mask_ff);

endmodule

// ### dv/osc_oring_ctrl_properties.sv
// Port checks for the ORing switch control block.
module osc_oring_ctrl_properties
    import osc_pkg::*;
(
    input logic MCLK,
    input logic RESET_N,
    input logic [7:0] ADDR,
    input logic [7:0] WDATA,
    input logic WR,
    input logic RD,
    input logic [7:0] RDATA,
    input logic SAMPLE_VALID,
    input logic signed [SENSE_W-1:0] REVERSE_SENSE_POS,
    input logic signed [SENSE_W-1:0] REVERSE_SENSE_NEG,
    input logic [SENSE_W-1:0] LOCAL_OUT_SENSE,
    input logic [SENSE_W-1:0] REMOTE_OUT_SENSE,
    input logic ORING_SWITCH_EN,
    input logic ACCURATE_FLAG,
    input logic IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic signed [DIFF_W-1:0] EN_TAB [4] = '{EN_THR_M0P5, EN_THR_0, EN_THR_1,
        EN_THR_2};
    localparam logic signed [DIFF_W-1:0] FT_TAB [4] = '{FAST_THR_M100, FAST_THR_M75,
        FAST_THR_M50, FAST_THR_M25};
    // A private copy of the configuration keeps the checker free of internal probes.
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic [4:0] run_ff;
    logic [4:0] nxt_run;
    logic [4:0] lim;
    logic signed [12:0] rev;
    logic signed [DIFF_W-1:0] od;
    logic cond;
    always_comb begin
        rev = 13'(REVERSE_SENSE_POS) - 13'(REVERSE_SENSE_NEG);
        od = $signed({2'h0, LOCAL_OUT_SENSE}) - $signed({2'h0, REMOTE_OUT_SENSE});
        cond = rev <= FT_TAB[cfg_ff[3:2]];
        lim = cfg_ff[1] ? 5'h14 : 5'h04;
        nxt_cfg = (WR && ADDR == ADDR_CONFIG) ? WDATA : cfg_ff;
        nxt_run = (!cond || cfg_ff[0]) ? 5'h00 : (run_ff == 5'h1F) ? run_ff : run_ff + 5'h01;
    end
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_ff <= CONFIG_RESET;
            run_ff <= 5'h00;
        end else begin
            cfg_ff <= nxt_cfg;
            run_ff <= nxt_run;
        end
    end
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);
    rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data not idle");
    cfg_read_a: assert property (RD && ADDR == ADDR_CONFIG |=> RDATA == $past(cfg_ff))
        else $error("config read differs");
    acc_set_a: assert property (SAMPLE_VALID && rev <= 0
        |=> ACCURATE_FLAG && !ORING_SWITCH_EN) else $error("accurate decision missed");
    acc_clr_a: assert property (SAMPLE_VALID && rev > 0 |=> !ACCURATE_FLAG)
        else $error("accurate flag stuck");
    flag_hold_a: assert property (!SAMPLE_VALID |=> $stable(ACCURATE_FLAG))
        else $error("flag moved without sample");
    en_on_a: assert property (SAMPLE_VALID && rev > 0
        && od > EN_TAB[cfg_ff[5:4]] |=> ORING_SWITCH_EN) else $error("switch not enabled");
    en_low_a: assert property (SAMPLE_VALID && !ORING_SWITCH_EN && od <= EN_TAB[cfg_ff[5:4]]
        |=> !ORING_SWITCH_EN) else $error("switch enabled below level");
    on_at_sample_a: assert property (!SAMPLE_VALID && !ORING_SWITCH_EN |=> !ORING_SWITCH_EN)
        else $error("switch enabled between samples");
    fast_trip_a: assert property (cond && !cfg_ff[0] && run_ff >= lim |=> !ORING_SWITCH_EN)
        else $error("fast disable late");
    hold_on_a: assert property (!SAMPLE_VALID && ORING_SWITCH_EN
        && (cfg_ff[0] || run_ff < lim) |=> ORING_SWITCH_EN) else $error("switch dropped early");
endmodule
bind osc_oring_ctrl osc_oring_ctrl_properties chk (.MCLK, .RESET_N, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .SAMPLE_VALID, .REVERSE_SENSE_POS, .REVERSE_SENSE_NEG, .LOCAL_OUT_SENSE,
    .REMOTE_OUT_SENSE, .ORING_SWITCH_EN, .ACCURATE_FLAG, .IRQ);

// ### dv/osc_fet_model.sv
// Model of the ORing MOSFET, its sense resistor and the sense converter strobe.
module osc_fet_model
    import osc_pkg::*;
(
    input logic clk,
    input logic conv,
    input logic sw_on,
    input logic signed [SENSE_W-1:0] cur,
    output logic sv,
    output logic signed [SENSE_W-1:0] pos,
    output logic signed [SENSE_W-1:0] neg
);
    timeunit 1ns;
    timeprecision 100ps;
    // Common-mode level of the sense pins; the value is arbitrary.
    localparam logic signed [SENSE_W-1:0] BIAS = 12'sh200;
    always @(posedge clk) sv <= conv;
    // With the channel off only the body diode conducts, so reverse current is blocked.
    assign neg = BIAS;
    assign pos = BIAS + ((sw_on || cur > 0) ? cur : 12'sh000);
endmodule

// ### dv/testbench.sv
// Self-checking testbench for the ORing switch control block.
module testbench
    import osc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, conv = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic signed [11:0] cur = 12'sh000, pos, neg;
    logic [11:0] loc = 12'h7D0, rem = 12'h7D0;
    logic sv, sw, flag, irq;
    int err_total = 0;
    int checked = 0;
    int lv [4] = '{-20, 0, 41, 82};
    int fl [4] = '{-100, -75, -50, -25};
    osc_oring_ctrl uut (.MCLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SAMPLE_VALID(sv), .REVERSE_SENSE_POS(pos),
        .REVERSE_SENSE_NEG(neg), .LOCAL_OUT_SENSE(loc), .REMOTE_OUT_SENSE(rem),
        .ORING_SWITCH_EN(sw), .ACCURATE_FLAG(flag), .IRQ(irq));
    osc_fet_model fet (.clk(clk), .conv(conv), .sw_on(sw), .cur(cur), .sv(sv), .pos(pos),
        .neg(neg));
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        cmp({7'h00, g}, {7'h00, e});
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(rdata, e);
    endtask
    // Converter strobe lands one cycle after the request, the decision one cycle later.
    task automatic smp(input int d, input int c);
        @(posedge clk);
        loc <= 12'(2000 + d);
        cur <= 12'(c);
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdc(ADDR_CONFIG, CONFIG_RESET);
        rdc(ADDR_IRQ_MASK, 8'h00);
        rdc(8'h10, 8'h00);
        wrr(ADDR_CONFIG, 8'h35);
        rdc(ADDR_CONFIG, 8'h35);
        $display("test reset done");
        wrr(ADDR_IRQ_MASK, 8'h07);
        for (int k = 0; k < 4; k++) begin
            wrr(ADDR_CONFIG, 8'(k << 4));
            smp(lv[k], 5);
            cmp1(sw, 1'b0);
            smp(lv[k] + 1, 5);
            cmp1(sw, 1'b1);
            cmp1(irq, 1'b1);
            smp(lv[k] + 1, -5);
            cmp1(sw, 1'b0);
            cmp1(flag, 1'b1);
            wrr(ADDR_IRQ_STATUS, 8'h07);
            #1 cmp1(irq, 1'b0);
        end
        $display("test enable done");
        for (int m = 0; m < 8; m++) begin
            wrr(ADDR_CONFIG, 8'((m % 4) << 2 | (m / 4) << 1));
            smp(100, 5);
            @(posedge clk);
            cur <= 12'(fl[m % 4] + 1);
            repeat (30) @(posedge clk);
            #1 cmp1(sw, 1'b1);
            @(posedge clk);
            cur <= 12'(fl[m % 4]);
            repeat (m < 4 ? 4 : 20) @(posedge clk);
            #1 cmp1(sw, 1'b1);
            @(posedge clk);
            #1 cmp1(sw, 1'b0);
        end
        rdc(ADDR_IRQ_STATUS, 8'h05);
        wrr(ADDR_IRQ_MASK, 8'h02);
        #1 cmp1(irq, 1'b0);
        wrr(ADDR_IRQ_MASK, 8'h07);
        #1 cmp1(irq, 1'b1);
        wrr(ADDR_IRQ_STATUS, 8'h05);
        #1 cmp1(irq, 1'b0);
        $display("test fast done");
        wrr(ADDR_CONFIG, 8'h01);
        smp(100, 5);
        @(posedge clk);
        cur <= -12'sh078;
        repeat (30) @(posedge clk);
        #1 cmp1(sw, 1'b1);
        smp(100, -120);
        cmp1(sw, 1'b0);
        wrr(ADDR_STATUS, 8'hFF);
        rdc(ADDR_STATUS, 8'h02);
        $display("test bypass done");
        conclude;
    end
endmodule
